// [s2ir_pkg.sv]
// constants for the serial2 event pending and enable registers
package s2ir_pkg;
  // apb geometry
  localparam int ADDR_W = 18;               // byte address width
  localparam int DATA_W = 32;               // apb data width
  localparam int EV_W   = 13;               // implemented flag bits

  // register indexes as printed, byte address is four times the index
  localparam logic [15:0] PEND_IDX = 16'h460E;
  localparam logic [15:0] EN_IDX   = 16'h4626;
  localparam logic [ADDR_W-1:0] PEND_ADDR = {PEND_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] EN_ADDR   = {EN_IDX, 2'b00};

  // values after reset
  localparam logic [EV_W-1:0]   PEND_RST  = 13'h0000;
  localparam logic [EV_W-1:0]   EN_RST    = 13'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // bit positions shared by both registers
  localparam int B_RX_DATA   = 0;   // rx_data_available
  localparam int B_TX_FREE   = 1;   // tx_buffer_free
  localparam int B_TX_IDLE   = 2;   // transmitter_idle
  localparam int B_RX_OVR    = 3;   // rx_overrun
  localparam int B_TX_UND    = 4;   // tx_underrun
  localparam int B_RX_DONE   = 5;   // rx_operation_done
  localparam int B_TX_DONE   = 6;   // tx_operation_done
  localparam int B_CMD_DONE  = 7;   // start_stop_done
  localparam int B_NACK      = 8;   // nack_received
  localparam int B_RXDMA_A   = 9;   // rx_dma_a_unloaded
  localparam int B_RXDMA_B   = 10;  // rx_dma_b_unloaded
  localparam int B_TXDMA_A   = 11;  // tx_dma_a_unloaded
  localparam int B_TXDMA_B   = 12;  // tx_dma_b_unloaded
endpackage

// [s2ir_regs.sv]
// serial2 event pending/enable registers with apb slave and irq request
`timescale 1ns/1ps
module s2ir_regs
  import s2ir_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // serial controller events, one-cycle pulses or levels
  input  wire logic              tx_dma_b_unloaded,
  input  wire logic              tx_dma_a_unloaded,
  input  wire logic              rx_dma_b_unloaded,
  input  wire logic              rx_dma_a_unloaded,
  input  wire logic              nack_received,
  input  wire logic              start_stop_done,
  input  wire logic              tx_operation_done,
  input  wire logic              rx_operation_done,
  input  wire logic              tx_underrun,
  input  wire logic              rx_overrun,
  input  wire logic              transmitter_idle,
  input  wire logic              tx_buffer_free,
  input  wire logic              rx_data_available,
  // request towards the cpu interrupt logic
  output logic                   serial2_irq
);

  // state
  logic [EV_W-1:0]   pend_reg;     // sticky pending flags
  logic [EV_W-1:0]   pend_next;    // next pending flags
  logic [EV_W-1:0]   en_reg;       // per-source enables
  logic [EV_W-1:0]   en_next;      // next enables
  logic [DATA_W-1:0] rdata_reg;    // registered read data
  logic [DATA_W-1:0] rdata_next;   // read data next
  logic              ready_reg;    // one wait state then ready
  logic              err_reg;      // unmapped access flag
  logic              irq_reg;      // interrupt request flop

  // decode
  wire logic            access_ph;  // access phase not yet answered
  wire logic            commit;     // edge at which transfer completes
  wire logic            hit_pend;   // pending register selected
  wire logic            hit_en;     // enable register selected
  wire logic            mapped;     // any register selected
  wire logic            wr_pend;    // write to pending commits
  wire logic            wr_en;      // write to enable commits
  wire logic [EV_W-1:0] ev;         // gathered event vector
  wire logic [EV_W-1:0] clr;        // write-one-to-clear mask
  wire logic [EV_W-1:0] rd_sel;     // selected register for read
  wire logic            irq_next;   // any enabled pending flag

  // transfer phases; the wait state is what lets every answer be a flop
  // limitation: an unmapped access still takes both access cycles
  assign access_ph = psel & penable & ~ready_reg;
  assign commit    = psel & penable & ready_reg;
  assign hit_pend  = (paddr == PEND_ADDR);
  assign hit_en    = (paddr == EN_ADDR);
  assign mapped    = hit_pend | hit_en;
  assign wr_pend   = commit & pwrite & hit_pend;
  assign wr_en     = commit & pwrite & hit_en;

  // event bit order follows the register layout
  assign ev[B_TXDMA_B]  = tx_dma_b_unloaded;
  assign ev[B_TXDMA_A]  = tx_dma_a_unloaded;
  assign ev[B_RXDMA_B]  = rx_dma_b_unloaded;
  assign ev[B_RXDMA_A]  = rx_dma_a_unloaded;
  assign ev[B_NACK]     = nack_received;
  assign ev[B_CMD_DONE] = start_stop_done;
  assign ev[B_TX_DONE]  = tx_operation_done;
  assign ev[B_RX_DONE]  = rx_operation_done;
  assign ev[B_TX_UND]   = tx_underrun;
  assign ev[B_RX_OVR]   = rx_overrun;
  assign ev[B_TX_IDLE]  = transmitter_idle;
  assign ev[B_TX_FREE]  = tx_buffer_free;
  assign ev[B_RX_DATA]  = rx_data_available;

  // only the write that commits may clear, and only ones clear
  assign clr = wr_pend ? pwdata[EV_W-1:0] : '0;

  // per-bit sticky flag; set wins over a clear in the same cycle
  // a clear never hides an event: the event term is ored in last
  genvar gi;
  generate
    for (gi = 0; gi < EV_W; gi++) begin : g_flag
      assign pend_next[gi] = ev[gi] | (pend_reg[gi] & ~clr[gi]);
    end
  endgenerate

  // enables are plain read/write, upper bits dropped
  // enables never change on their own, only by a committed write
  assign en_next = wr_en ? pwdata[EV_W-1:0] : en_reg;

  // read mux, bits above 12 read as zero
  // unmapped reads fall through to zero, the error flag explains them
  assign rd_sel     = hit_pend ? pend_reg : (hit_en ? en_reg : '0);
  assign rdata_next = {{(DATA_W-EV_W){1'b0}}, rd_sel};

  // request follows pending and enable with one flop of delay
  assign irq_next = |(pend_reg & en_reg);

  // flag and enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= PEND_RST;
      en_reg   <= EN_RST;
    end else begin
      pend_reg <= pend_next;
      en_reg   <= en_next;
    end
  end

  // apb answer: one wait state keeps every output a flop
  // limitation: no byte strobes, a write always moves the whole word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= RDATA_RST;
    end else begin
      ready_reg <= access_ph;
      err_reg   <= access_ph & ~mapped;
      // data captured while address is held, cleared otherwise
      if (access_ph && !pwrite) begin
        rdata_reg <= rdata_next;
      end else begin
        rdata_reg <= RDATA_RST;
      end
    end
  end

  // interrupt request flop
  // one cycle of lag traded for a glitch-free request line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // outputs straight from flops
  assign prdata      = rdata_reg;
  assign pready      = ready_reg;
  assign pslverr     = err_reg;
  assign serial2_irq = irq_reg;

  // checks on the design's own outputs and state
  property p_set_next(logic cause, logic flag);
    @(posedge pclk) disable iff (!presetn)
      cause |=> flag;
  endproperty

  // written tx dma enable bits appear on the next edge
  AST_EN_TXDMA_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
      wr_en |=> (en_reg[B_TXDMA_B] == $past(pwdata[B_TXDMA_B]))
             && (en_reg[B_TXDMA_A] == $past(pwdata[B_TXDMA_A])))
    else $error("tx dma enables did not take written value");

  AST_PEND_TXDMA: assert property (
    @(posedge pclk) disable iff (!presetn)
      (tx_dma_a_unloaded || tx_dma_b_unloaded) |=>
        (pend_reg[B_TXDMA_A] || !$past(tx_dma_a_unloaded))
        && (pend_reg[B_TXDMA_B] || !$past(tx_dma_b_unloaded)))
    else $error("tx dma unload not flagged");

  AST_PEND_RXDMA: assert property (
    @(posedge pclk) disable iff (!presetn)
      (rx_dma_a_unloaded || rx_dma_b_unloaded) |=>
        (pend_reg[B_RXDMA_A] || !$past(rx_dma_a_unloaded))
        && (pend_reg[B_RXDMA_B] || !$past(rx_dma_b_unloaded)))
    else $error("rx dma unload not flagged");

  AST_IDLE_GATED: assert property (
    @(posedge pclk) disable iff (!presetn)
      (pend_reg == 13'h0004 && !en_reg[B_TX_IDLE]) ##1
      (pend_reg == 13'h0004 && !en_reg[B_TX_IDLE]) |-> !serial2_irq)
    else $error("idle flag raised irq while disabled");

  AST_PEND_IDLE: assert property (
    p_set_next(transmitter_idle, pend_reg[B_TX_IDLE]))
    else $error("transmitter idle not flagged");

  AST_PEND_NACK: assert property (
    p_set_next(nack_received, pend_reg[B_NACK]))
    else $error("nack not flagged at bit 8");

  AST_FLAG_STICKY: assert property (
    @(posedge pclk) disable iff (!presetn)
      (pend_reg[B_RX_OVR] && !wr_pend) |=> pend_reg[B_RX_OVR])
    else $error("overrun flag dropped without a clear");

  AST_IRQ_FOLLOWS: assert property (
    @(posedge pclk) disable iff (!presetn)
      ((pend_reg & en_reg) != '0) |=> serial2_irq)
    else $error("irq missing for enabled pending flag");

  AST_UPPER_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
      pready |-> (prdata[DATA_W-1:EV_W] == '0))
    else $error("bits above 12 not zero");

  AST_APB_WAIT: assert property (
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");

  // enables for rx dma unloads take the written value
  AST_EN_RXDMA_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
      wr_en |=> (en_reg[B_RXDMA_B] == $past(pwdata[B_RXDMA_B]))
             && (en_reg[B_RXDMA_A] == $past(pwdata[B_RXDMA_A])))
    else $error("rx dma enables did not take written value");

  // the idle enable is an ordinary read/write bit
  AST_EN_IDLE_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
      wr_en |=> (en_reg[B_TX_IDLE] == $past(pwdata[B_TX_IDLE])))
    else $error("idle enable did not take written value");

  // low two flags follow buffer free and data available
  AST_PEND_LOW: assert property (
    @(posedge pclk) disable iff (!presetn)
      (tx_buffer_free || rx_data_available) |=>
        (pend_reg[B_TX_FREE] || !$past(tx_buffer_free))
        && (pend_reg[B_RX_DATA] || !$past(rx_data_available)))
    else $error("tx free or rx data not flagged");

  // two-wire completions and underrun land in bits 7..4
  AST_PEND_MID: assert property (
    @(posedge pclk) disable iff (!presetn)
      ((pend_reg[B_CMD_DONE:B_TX_UND]
        & $past({start_stop_done, tx_operation_done,
                 rx_operation_done, tx_underrun}))
       == $past({start_stop_done, tx_operation_done,
                 rx_operation_done, tx_underrun})))
    else $error("two-wire or underrun event not flagged");

  // an event in the commit cycle of a clearing write survives it
  AST_SET_WINS: assert property (
    @(posedge pclk) disable iff (!presetn)
      wr_pend |=> ((pend_reg & $past(ev)) == $past(ev)))
    else $error("event lost to a clear in the same cycle");

  // only ones clear, and only bits with no event behind them
  AST_CLEAR_ONES: assert property (
    @(posedge pclk) disable iff (!presetn)
      wr_pend |=>
        ((pend_reg & $past(clr) & ~$past(ev)) == '0))
    else $error("written one did not clear its flag");

  // a flag only rises on the edge after its event
  AST_PEND_CAUSE: assert property (
    @(posedge pclk) disable iff (!presetn)
      ((pend_reg & ~$past(pend_reg) & ~$past(ev)) == '0))
    else $error("flag rose with no event behind it");

  // no enabled flag, no request one edge later
  AST_IRQ_QUIET: assert property (
    @(posedge pclk) disable iff (!presetn)
      ((pend_reg & en_reg) == '0) |=> !serial2_irq)
    else $error("irq raised with no enabled pending flag");

  // error is only ever shown together with ready
  AST_ERR_WITH_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
    else $error("pslverr without pready");

  // read data is zero outside the ready cycle
  AST_RDATA_IDLE: assert property (
    @(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == '0))
    else $error("read data not zero outside ready");

  // main scenarios
  // request comes up for an enabled flag
  COV_IRQ_RAISE: cover property (
    @(posedge pclk) disable iff (!presetn)
      !serial2_irq ##1 serial2_irq);
  // event and clear meet in one commit cycle
  COV_CLEAR_RACE: cover property (
    @(posedge pclk) disable iff (!presetn)
      wr_pend && ((ev & clr) != '0));
  // access outside both registers
  COV_UNMAPPED: cover property (
    @(posedge pclk) disable iff (!presetn)
      pready && pslverr);
  // enables written to something nonzero
  COV_ENABLE_WRITE: cover property (
    @(posedge pclk) disable iff (!presetn)
      wr_en ##1 (en_reg != '0));
  // request drops after a clear or a disable
  COV_IRQ_FALL: cover property (
    @(posedge pclk) disable iff (!presetn)
      serial2_irq ##1 !serial2_irq);

endmodule

// [s2ir_evsrc.sv]
// serial controller event source model, one-cycle pulses
`timescale 1ns/1ps
module s2ir_evsrc (
  // clock
  input  wire logic        pclk,
  // event lines in register bit order
  output logic      [12:0] ev
);
  initial ev = 13'h0000;  // quiet until asked
  // pulse launched after an edge, dropped one edge later
  task automatic pulse(input logic [12:0] m);
    @(posedge pclk) ev <= m;
    @(posedge pclk) ev <= 13'h0000;
  endtask
endmodule

// [tb_s2ir_regs.sv]
// self-checking bench for the serial2 event registers
`timescale 1ns/1ps
module tb_s2ir_regs;
  import s2ir_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              pready, pslverr, serial2_irq, er;
  logic [12:0]       ev, pm, em, m;  // pm, em: expected registers
  logic [31:0]       seed;
  int                mismatches, compares, i;

  s2ir_evsrc src_u (.pclk(pclk), .ev(ev));
  s2ir_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial2_irq(serial2_irq),
    .tx_dma_b_unloaded(ev[B_TXDMA_B]), .tx_dma_a_unloaded(ev[B_TXDMA_A]),
    .rx_dma_b_unloaded(ev[B_RXDMA_B]), .rx_dma_a_unloaded(ev[B_RXDMA_A]),
    .nack_received(ev[B_NACK]), .start_stop_done(ev[B_CMD_DONE]),
    .tx_operation_done(ev[B_TX_DONE]), .rx_operation_done(ev[B_RX_DONE]),
    .tx_underrun(ev[B_TX_UND]), .rx_overrun(ev[B_RX_OVR]),
    .transmitter_idle(ev[B_TX_IDLE]), .tx_buffer_free(ev[B_TX_FREE]),
    .rx_data_available(ev[B_RX_DATA]));

  // xorshift, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // request expected from flags and enables
  function automatic logic exp_irq(logic [12:0] p, logic [12:0] e);
    return |(p & e);
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0s expected %h seen %h", nm, exp, got);
    end
  endtask

  // single-bit results: request line and error flag
  task automatic chk_bit(input string nm, input logic exp, got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0s expected %b seen %b", nm, exp, got);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no timeout here, only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // watchdog, far past the several hundred cycles needed
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    seed = 32'h0000_0013;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = '0;
    pwdata = '0;
    pm = '0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped place
    apb(1'b0, PEND_ADDR, 32'h0);
    chk("pend_rst", {19'h0, PEND_RST}, rd);
    apb(1'b0, EN_ADDR, 32'h0);
    chk("en_rst", {19'h0, EN_RST}, rd);
    chk_bit("irq_rst", 1'b0, serial2_irq);
    apb(1'b0, EN_ADDR + 18'h4, 32'h0);
    chk_bit("bad_err", 1'b1, er);
    chk("bad_rd", 32'h0, rd);
    $display("test reset_unmapped done");
    // each source alone: sticky flag, gated request, write-one clear
    for (i = 0; i < EV_W; i++) begin
      m = 13'h0001 << i;
      apb(1'b1, EN_ADDR, {19'h7FFFF, m});  // junk above bit 12
      apb(1'b0, EN_ADDR, 32'h0);
      chk("en_rd", {19'h0, m}, rd);
      src_u.pulse(m);
      apb(1'b0, PEND_ADDR, 32'h0);
      chk("pend_rd", {19'h0, m}, rd);
      chk_bit("irq_on", 1'b1, serial2_irq);
      apb(1'b1, EN_ADDR, {19'h0, ~m});
      repeat (2) @(posedge pclk);
      chk_bit("irq_off", 1'b0, serial2_irq);
      apb(1'b1, PEND_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, PEND_ADDR, 32'h0);
      chk("pend_clr", 32'h0, rd);
    end
    $display("test single_source done");
    // random events, enables and partial clears
    for (i = 0; i < 20; i++) begin
      em = 13'(rnd());
      apb(1'b1, EN_ADDR, {19'h0, em});
      m = 13'(rnd());
      src_u.pulse(m);
      pm = pm | m;
      m = 13'(rnd());
      apb(1'b1, PEND_ADDR, {19'h0, m});
      pm = pm & ~m;
      apb(1'b0, PEND_ADDR, 32'h0);
      chk("pend_mix", {19'h0, pm}, rd);
      chk_bit("irq_mix", exp_irq(pm, em), serial2_irq);
    end
    $display("test random_mix done");
    // corner: every event high in the commit cycle of a clear-all
    m = 13'h1FFF;
    fork
      apb(1'b1, PEND_ADDR, 32'hFFFF_FFFF);
      begin
        repeat (2) @(posedge pclk);
        src_u.pulse(m);
      end
    join
    apb(1'b0, PEND_ADDR, 32'h0);
    chk("pend_race", {19'h0, m}, rd);
    $display("test clear_race done");
    // corner: reset in mid-run drops flags, enables and request
    apb(1'b1, EN_ADDR, {19'h0, m});
    apb(1'b0, EN_ADDR, 32'h0);
    chk_bit("irq_pre", 1'b1, serial2_irq);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk_bit("irq_rrst", 1'b0, serial2_irq);
    apb(1'b0, PEND_ADDR, 32'h0);
    chk("pend_rrst", 32'h0, rd);
    apb(1'b0, EN_ADDR, 32'h0);
    chk("en_rrst", 32'h0, rd);
    $display("test midrun_reset done");
    give_verdict();
  end
endmodule
